// File: rtl/i2cmem_slave.sv
// Two-wire serial slave front end for a 64K x 8 byte memory.
//
// Function
// - Array of 65536 bytes, contents retained.
// - Sample SDA on SCL rise, drive after fall.
// - SDA only pulled low or released.
// - SDA changes only while SCL low.
// - SDA fall with SCL high is start.
// - Stop ends transfer, returns to standby.
// - Upper four selection bits must be 1010.
// - Next three bits compared to strap levels.
// - Acknowledge only on matching strap code.
// - Open strap inputs read as low.
// - Mismatch leaves device idle until stop or start.
// - Eighth selection bit selects read or write.
// - Ninth clock carries receiver acknowledge.
// - Two address bytes follow write selection.
// - Each write byte acknowledged low.
// - Read sends eight bits, samples master ack.
// - Stop before acknowledge aborts to standby.
// - After not-acknowledge release bus.
// - Write lock high inhibits writes, reads work.
// - Write commits at once, no wait.
// - Never withhold acknowledge for busy.
// - Address increments per byte, wraps to zero.
// - Current read uses next after last address.
// - Random read via repeated start.
// - High-speed entry byte not acknowledged.
`timescale 1ns/1ps
module i2cmem_slave
    import i2cmem_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       sclIn,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe,
    input  wire logic [2:0] chipSelectStraps,
    input  wire logic       writeLockPin,
    output logic            busySel,
    output logic            highSpeed
);
    logic [1:0] sclSync_reg;
    logic [1:0] sdaSync_reg;
    logic [2:0] strapSync_reg [2];
    logic [1:0] lockSync_reg;
    logic       sclD_reg;
    logic       sdaD_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // SCL and SDA synchronisers start at the idle high bus level, so no false edge.
            sclSync_reg      <= 2'h3;
            sdaSync_reg      <= 2'h3;
            strapSync_reg[0] <= 3'h0;
            strapSync_reg[1] <= 3'h0;
            lockSync_reg     <= 2'h0;
            sclD_reg         <= 1'b1;
            sdaD_reg         <= 1'b1;
        end else begin
            sclSync_reg      <= {sclSync_reg[0], sclIn};
            sdaSync_reg      <= {sdaSync_reg[0], sdaIn};
            strapSync_reg[0] <= chipSelectStraps;
            strapSync_reg[1] <= strapSync_reg[0];
            lockSync_reg     <= {lockSync_reg[0], writeLockPin};
            sclD_reg         <= sclSync_reg[1];
            sdaD_reg         <= sdaSync_reg[1];
        end
    end

    wire       scl     = sclSync_reg[1];
    wire       sda     = sdaSync_reg[1];
    // Straps and lock pulled low externally when open; sync sees low.
    wire [2:0] straps  = strapSync_reg[1];
    wire       locked  = lockSync_reg[1];
    wire       sclRise = scl && !sclD_reg;
    wire       sclFall = !scl && sclD_reg;
    wire       startC  = scl && sclD_reg && sdaD_reg && !sda;
    wire       stopC   = scl && sclD_reg && !sdaD_reg && sda;

    imst_state_t       state_reg;
    imst_state_t       state_next;
    logic [3:0]        bitCnt_reg;
    logic [7:0]        shift_reg;
    logic [15:0]       addr_reg;
    logic              first_reg;
    logic              ackDrive_reg;
    logic              masterNack_reg;
    logic [7:0]        txByte_reg;
    logic              wrValid_reg;
    imst_wr_t          wrData_reg;
    logic              bufInReady;
    logic              bufOutValid;
    logic [$bits(imst_wr_t)-1:0] bufOut;
    imst_wr_t          bufWr;
    logic [7:0]        rdData;

    wire [7:0]  rxByte  = shift_reg;
    wire        selHit  = (rxByte[7:4] == TYPE_CODE)
                          && (rxByte[3:1] == straps);
    wire        hsEntry = (rxByte[7:4] == HS_ENTRY_HI) && rxByte[3];
    wire        isRead  = rxByte[0];
    wire        ackSlot = (bitCnt_reg == BIT_ACK);
    wire        byteEnd = sclFall && (bitCnt_reg == BIT_LAST);
    wire        ackEnd  = sclFall && ackSlot;
    wire [15:0] addrInc = addr_reg + 16'h0001;
    wire        drain   = bufOutValid;

    assign bufWr = imst_wr_t'(bufOut);

    i2cmem_buf u_buf (
        .clk      (clk),
        .rst      (rst),
        .inValid  (wrValid_reg),
        .inReady  (bufInReady),
        .inData   (wrData_reg),
        .outValid (bufOutValid),
        .outReady (1'b1),
        .outData  (bufOut)
    );

    // Commit happens right after the eighth data bit, during the acknowledge clock; no busy period exists.
    i2cmem_ram u_ram (
        .clk    (clk),
        .wrEn   (drain),
        .wrReq  (bufWr),
        .rdAddr (addr_reg),
        .rdData (rdData)
    );

    always_comb begin
        state_next = state_reg;
        if (ackEnd) begin
            case (state_reg)
                IMST_SEL:  state_next = !ackDrive_reg ? IMST_HOLD :
                                        isRead ? IMST_RDAT : IMST_ADRH;
                IMST_ADRH: state_next = IMST_ADRL;
                IMST_ADRL: state_next = IMST_WDAT;
                IMST_WDAT: state_next = IMST_WDAT;
                IMST_RDAT: state_next = masterNack_reg ? IMST_HOLD
                                        : IMST_RDAT;
                default:   state_next = state_reg;
            endcase
        end
        if (startC) begin
            state_next = IMST_SEL;
        end
        if (stopC) begin
            state_next = IMST_IDLE;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= IMST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    wire rxState = (state_reg == IMST_SEL) || (state_reg == IMST_ADRH)
                   || (state_reg == IMST_ADRL) || (state_reg == IMST_WDAT);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bitCnt_reg     <= 4'h0;
            shift_reg      <= 8'h00;
            addr_reg       <= ADDR_RESET;
            first_reg      <= 1'b0;
            ackDrive_reg   <= 1'b0;
            masterNack_reg <= 1'b0;
            txByte_reg     <= 8'hFF;
            wrValid_reg    <= 1'b0;
            wrData_reg     <= '0;
            sdaOut         <= 1'b0;
            sdaOe          <= 1'b0;
            busySel        <= 1'b0;
            highSpeed      <= 1'b0;
        end else begin
            wrValid_reg <= 1'b0;
            if (sclRise) begin
                if (ackSlot) begin
                    masterNack_reg <= sda;
                end else begin
                    shift_reg <= {shift_reg[6:0], sda};
                end
            end
            if (sclFall) begin
                bitCnt_reg <= ackSlot ? 4'h0 : bitCnt_reg + 4'h1;
            end
            if (byteEnd) begin
                ackDrive_reg <= 1'b0;
                case (state_reg)
                    IMST_SEL: begin
                        ackDrive_reg <= selHit;
                        if (first_reg && hsEntry) begin
                            highSpeed <= 1'b1;
                        end
                    end
                    IMST_ADRH: begin
                        addr_reg[15:8] <= rxByte;
                        ackDrive_reg   <= 1'b1;
                    end
                    IMST_ADRL: begin
                        addr_reg[7:0] <= rxByte;
                        ackDrive_reg  <= 1'b1;
                    end
                    IMST_WDAT: begin
                        ackDrive_reg <= 1'b1;
                        if (!locked && bufInReady) begin
                            wrValid_reg <= 1'b1;
                            wrData_reg  <= '{addr: addr_reg, data: rxByte};
                        end
                        addr_reg <= addrInc;
                    end
                    default: ackDrive_reg <= 1'b0;
                endcase
            end
            if (ackEnd && state_reg == IMST_SEL && ackDrive_reg && isRead) begin
                txByte_reg <= rdData;
                addr_reg   <= addrInc;
            end
            if (ackEnd && state_reg == IMST_RDAT && !masterNack_reg) begin
                txByte_reg <= rdData;
                addr_reg   <= addrInc;
            end
            if (sclFall) begin
                // Drive after the falling edge only.
                sdaOut <= 1'b0;
                if (byteEnd && rxState) begin
                    sdaOe <= (state_reg == IMST_SEL) ? selHit : 1'b1;
                end else if (state_next == IMST_RDAT && !ackSlot
                             && bitCnt_reg != BIT_LAST) begin
                    sdaOe <= !txByte_reg[BIT_LAST[2:0] - 3'h1
                                         - bitCnt_reg[2:0]];
                end else if (ackEnd && state_next == IMST_RDAT) begin
                    sdaOe <= !rdData[7];
                end else begin
                    sdaOe <= 1'b0;
                end
            end
            if (startC) begin
                // The clock fall that closes a start is not a data bit.
                bitCnt_reg <= BIT_SKIP;
                first_reg  <= 1'b1;
                sdaOe      <= 1'b0;
            end else if (byteEnd) begin
                first_reg <= 1'b0;
            end
            if (stopC) begin
                sdaOe     <= 1'b0;
                highSpeed <= 1'b0;
                busySel   <= 1'b0;
            end else if (state_reg != IMST_IDLE && state_reg != IMST_HOLD) begin
                busySel <= 1'b1;
            end else begin
                busySel <= 1'b0;
            end
        end
    end

    property p_sda_low_only;
        @(posedge clk) disable iff (rst) sdaOe |-> !sdaOut;
    endproperty
    a_sda_low_only: assert property (p_sda_low_only)
        else $error("SDA driven high");

    property p_oe_change_scl_low;
        @(posedge clk) disable iff (rst)
        $rose(sdaOe) |-> !$past(sclSync_reg[1]);
    endproperty
    a_oe_change_scl_low: assert property (p_oe_change_scl_low)
        else $error("SDA enable rose with SCL high");

    property p_stop_idle;
        @(posedge clk) disable iff (rst) stopC |=> state_reg == IMST_IDLE;
    endproperty
    a_stop_idle: assert property (p_stop_idle)
        else $error("Stop did not return to idle");

    property p_start_sel;
        @(posedge clk) disable iff (rst)
        (startC && !stopC) |=> state_reg == IMST_SEL;
    endproperty
    a_start_sel: assert property (p_start_sel)
        else $error("Start not seen");

    property p_stop_release;
        @(posedge clk) disable iff (rst) stopC |=> !sdaOe;
    endproperty
    a_stop_release: assert property (p_stop_release)
        else $error("Bus held after stop");

    property p_nomatch_silent;
        @(posedge clk) disable iff (rst)
        (byteEnd && state_reg == IMST_SEL && !selHit) |=> !sdaOe;
    endproperty
    a_nomatch_silent: assert property (p_nomatch_silent)
        else $error("Acknowledged foreign selection");

    property p_match_ack;
        @(posedge clk) disable iff (rst)
        (byteEnd && state_reg == IMST_SEL && selHit && !startC && !stopC)
        |=> sdaOe;
    endproperty
    a_match_ack: assert property (p_match_ack)
        else $error("Matching selection not acknowledged");

    property p_lock_nowrite;
        @(posedge clk) disable iff (rst) (byteEnd && locked) |=> !wrValid_reg;
    endproperty
    a_lock_nowrite: assert property (p_lock_nowrite)
        else $error("Write while locked");

    property p_data_ack;
        @(posedge clk) disable iff (rst)
        (byteEnd && state_reg == IMST_WDAT && !startC && !stopC) |=> sdaOe;
    endproperty
    a_data_ack: assert property (p_data_ack)
        else $error("Write byte not acknowledged");

    property p_hold_released;
        @(posedge clk) disable iff (rst)
        (state_reg == IMST_HOLD && $past(state_reg) == IMST_HOLD) |-> !sdaOe;
    endproperty
    a_hold_released: assert property (p_hold_released)
        else $error("Bus not released after not-acknowledge");
endmodule

// File: rtl/i2cmem_pkg.sv
// Package with constants and types for the two-wire byte memory slave.
package i2cmem_pkg;
    localparam int          MEM_DEPTH      = 65536;
    localparam int          ADDR_W         = 16;
    localparam int          DATA_W         = 8;
    localparam logic [3:0]  TYPE_CODE      = 4'hA;
    localparam logic [3:0]  HS_ENTRY_HI    = 4'h0;
    localparam logic [3:0]  BIT_LAST       = 4'h7;
    localparam logic [3:0]  BIT_ACK        = 4'h8;
    localparam logic [3:0]  BIT_SKIP       = 4'hF;
    localparam logic [15:0] ADDR_RESET     = 16'h0000;
    localparam int          SYNC_STAGES    = 2;

    typedef enum logic [2:0] {
        IMST_IDLE  = 3'b000,
        IMST_SEL   = 3'b001,
        IMST_ADRH  = 3'b011,
        IMST_ADRL  = 3'b010,
        IMST_WDAT  = 3'b110,
        IMST_RDAT  = 3'b111,
        IMST_HOLD  = 3'b101
    } imst_state_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  data;
    } imst_wr_t;
endpackage

// File: rtl/i2cmem_ram.sv
// Byte memory array with registered read data.
`timescale 1ns/1ps
module i2cmem_ram
    import i2cmem_pkg::*;
#(
    parameter int DEPTH = MEM_DEPTH
) (
    input  wire logic              clk,
    input  wire logic              wrEn,
    input  wire imst_wr_t          wrReq,
    input  wire logic [ADDR_W-1:0] rdAddr,
    output logic      [DATA_W-1:0] rdData
);
    logic [DATA_W-1:0] mem [DEPTH];

    // Array has no reset so contents persist like the nonvolatile cells.
    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrReq.addr] <= wrReq.data;
        end
        rdData <= mem[rdAddr];
    end
endmodule

// File: rtl/i2cmem_buf.sv
// Two-entry valid/ready buffer for write requests.
`timescale 1ns/1ps
module i2cmem_buf
    import i2cmem_pkg::*;
#(
    parameter int WIDTH = $bits(imst_wr_t)
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    logic [WIDTH-1:0] slot_reg [2];
    logic             wp_reg;
    logic             rp_reg;
    logic [1:0]       cnt_reg;
    wire              push = inValid && inReady;
    wire              pop  = outValid && outReady;

    assign inReady  = (cnt_reg != 2'h2);
    assign outValid = (cnt_reg != 2'h0);
    assign outData  = slot_reg[rp_reg];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_reg  <= 1'b0;
            rp_reg  <= 1'b0;
            cnt_reg <= 2'h0;
        end else begin
            if (push) wp_reg <= ~wp_reg;
            if (pop) rp_reg <= ~rp_reg;
            cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge clk) begin
        if (push) slot_reg[wp_reg] <= inData;
    end
endmodule

// File: sim/i2cmem_master_model.sv
// Bus master model that clocks the serial link and moves bytes.
`timescale 1ns/1ps
module i2cmem_master_model (
    input  wire logic clk,
    input  wire logic sdaOe,
    output logic      sclPin,
    output logic      sdaWire
);
    logic masterPull;
    int   lowExtra;

    // Open-drain wire with pull-up, low while either party pulls.
    assign sdaWire = !(masterPull || sdaOe);

    initial begin
        sclPin = 1'b1;
        masterPull = 1'b0;
        lowExtra = 0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One clock pulse, data changed only while the clock is low.
    task automatic bit_cycle(input logic b, output logic s);
        tick(4 + lowExtra);
        masterPull = !b;
        tick(4);
        sclPin = 1'b1;
        tick(4);
        s = sdaWire;
        tick(4);
        sclPin = 1'b0;
    endtask

    task automatic start_cond();
        tick(4);
        masterPull = 1'b0;
        tick(4);
        sclPin = 1'b1;
        tick(8);
        masterPull = 1'b1;
        tick(8);
        sclPin = 1'b0;
    endtask

    task automatic stop_cond();
        tick(4);
        masterPull = 1'b1;
        tick(4);
        sclPin = 1'b1;
        tick(8);
        masterPull = 1'b0;
        tick(8);
    endtask

    // Sends the top n bits, then the acknowledge clock for a whole byte.
    task automatic send_bits(input logic [7:0] v, input int n,
                             output logic ack);
        logic s;
        for (int i = 7; i > 7 - n; i--) bit_cycle(v[i], s);
        ack = 1'b0;
        if (n == 8) begin
            bit_cycle(1'b1, s);
            ack = !s;
        end
    endtask

    task automatic read_byte(input logic ackIt, output logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) bit_cycle(1'b1, v[i]);
        bit_cycle(!ackIt, s);
    endtask
endmodule

// File: sim/i2cmem_slave_tb_top.sv
// Testbench for the two-wire byte memory slave.
`timescale 1ns/1ps
module i2cmem_slave_tb_top
    import i2cmem_pkg::*;
;
    localparam logic [7:0] YES = 8'h01;
    localparam logic [7:0] NO  = 8'h00;
    logic        clk;
    logic        rst;
    logic [2:0]  straps;
    logic        lockPin;
    logic        sdaOut;
    logic        sdaOe;
    logic        busySel;
    logic        highSpeed;
    logic        sclPin;
    logic        sdaWire;
    logic        oePrev;
    logic        sclPrev;
    logic [7:0]  memModel [logic [15:0]];
    logic [15:0] ptr;
    logic [3:0]  badType [4] = '{4'h2, 4'h8, 4'hB, 4'hE};
    int          miscompares;
    int          num_checks;

    i2cmem_slave u_i2cmem_slave (
        .clk              (clk),
        .rst              (rst),
        .sclIn            (sclPin),
        .sdaIn            (sdaWire),
        .sdaOut           (sdaOut),
        .sdaOe            (sdaOe),
        .chipSelectStraps (straps),
        .writeLockPin     (lockPin),
        .busySel          (busySel),
        .highSpeed        (highSpeed)
    );

    i2cmem_master_model u_m (
        .clk     (clk),
        .sdaOe   (sdaOe),
        .sclPin  (sclPin),
        .sdaWire (sdaWire)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Watches the wire: output level and steadiness while the clock is high.
    always @(posedge clk) begin
        if (!rst) begin
            chk("sda out level", NO, 8'(sdaOut));
            if (sclPin && sclPrev) begin
                chk("sda steady", 8'(oePrev), 8'(sdaOe));
            end
        end
        oePrev <= sdaOe;
        sclPrev <= sclPin;
    end

    task automatic set_addr(input logic [15:0] a);
        logic ack;
        u_m.start_cond();
        u_m.send_bits({TYPE_CODE, straps, 1'b0}, 8, ack);
        chk("write sel ack", YES, 8'(ack));
        u_m.send_bits(a[15:8], 8, ack);
        chk("addr hi ack", YES, 8'(ack));
        u_m.send_bits(a[7:0], 8, ack);
        chk("addr lo ack", YES, 8'(ack));
    endtask

    task automatic write_seq(input logic [15:0] a, input int n);
        logic       ack;
        logic [7:0] d;
        set_addr(a);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            u_m.send_bits(d, 8, ack);
            chk("data ack", YES, 8'(ack));
            if (!lockPin) memModel[a] = d;
            a++;
        end
        u_m.stop_cond();
        ptr = a;
    endtask

    task automatic read_seq(input logic withAddr, input logic [15:0] a,
                            input int n);
        logic       ack;
        logic [7:0] d;
        if (withAddr) begin
            set_addr(a);
        end else begin
            a = ptr;
        end
        u_m.start_cond();
        u_m.send_bits({TYPE_CODE, straps, 1'b1}, 8, ack);
        chk("read sel ack", YES, 8'(ack));
        for (int i = 0; i < n; i++) begin
            u_m.read_byte(i < n - 1, d);
            chk("read data", memModel[a], d);
            a++;
        end
        u_m.tick(6);
        chk("release after nack", NO, 8'(sdaOe));
        u_m.stop_cond();
        ptr = a;
    endtask

    initial begin
        #900000;
        miscompares++;
        $display("BAD watchdog expected finish seen timeout");
        stop_test();
    end

    initial begin
        logic        ack;
        logic [15:0] a;
        int          n;
        rst = 1'b1;
        lockPin = 1'b0;
        straps = 3'h0;
        miscompares = 0;
        num_checks = 0;
        void'($urandom(32'hE62FAD45));
        repeat (2) @(posedge clk);
        chk("reset oe", NO, 8'(sdaOe));
        chk("reset busy", NO, 8'(busySel));
        #1 rst = 1'b0;
        u_m.tick(4);
        straps = 3'($urandom);
        for (int c = 0; c < 8; c++) begin
            u_m.start_cond();
            u_m.send_bits({TYPE_CODE, 3'(c), 1'b0}, 8, ack);
            chk("strap ack", 8'(c == straps), 8'(ack));
            u_m.tick(6);
            chk("strap busy", 8'(c == straps), 8'(busySel));
            u_m.send_bits(8'hC3, 8, ack);
            chk("next byte ack", 8'(c == straps), 8'(ack));
            u_m.stop_cond();
            chk("idle after stop", NO, 8'(busySel));
        end
        foreach (badType[i]) begin
            u_m.start_cond();
            u_m.send_bits({badType[i], straps, 1'b1}, 8, ack);
            chk("bad type ack", NO, 8'(ack));
            u_m.stop_cond();
        end
        u_m.start_cond();
        u_m.send_bits({5'h01, 3'($urandom)}, 8, ack);
        chk("entry byte ack", NO, 8'(ack));
        chk("fast mode", YES, 8'(highSpeed));
        u_m.stop_cond();
        chk("fast mode off", NO, 8'(highSpeed));
        write_seq(16'hFFFE, 4);
        read_seq(1'b1, 16'hFFFE, 4);
        lockPin = 1'b1;
        write_seq(16'hFFFF, 2);
        read_seq(1'b1, 16'hFFFE, 4);
        lockPin = 1'b0;
        set_addr(16'h0000);
        u_m.send_bits(8'h5A, 4, ack);
        u_m.stop_cond();
        chk("abort idle", NO, 8'(busySel));
        read_seq(1'b1, 16'h0000, 1);
        repeat (6) begin
            a = 16'($urandom);
            n = 1 + $urandom % 4;
            straps = 3'($urandom);
            u_m.lowExtra = $urandom % 3;
            write_seq(a, n + 1);
            read_seq(1'b1, a, n);
            read_seq(1'b0, a, 1);
        end
        stop_test();
    end
endmodule
